// ==== sac_adc_ctrl.sv ====
// Functional notes
// RULE1: sequencer steps on oscillator clock divided by 12 or 6.
// RULE2: divide by 12 is used after reset until software selects 6.
// RULE3: eight-bit result built by successive approximation, placed in result register.
// RULE4: writing trigger one starts conversion and clears done flag together.
// RULE5: done flag set at completion; result valid from then on.
// RULE6: one conversion per trigger write, never restarting on its own.
// RULE7: trigger written during a conversion abandons it and starts anew.
// RULE8: trigger bit is write-only and always reads as zero.
// RULE9: interrupt request equals done flag gated by done interrupt enable.
// RULE10: converter powered only while analog power bit is one.
// RULE11: software sets power bit at least one instruction before triggering.
// RULE12: processor wait mode does not power down converter or comparator.
// RULE13: reset stops conversion and loads control register with 40h.
// RULE14: software selects at most one analog input line at a time.
// RULE15: control bits 7 irq enable, 6 done, 5 trigger, 4 power, 2 clock.
// RULE16: clock divider select one divides by 6, zero by 12.
// RULE17: control register at index d1h, result register at index d0h.
// RULE18: result holds last completed value; aborted conversions never update it; a power-off abort on the final bit step still loads it.
////////////////////////////////////////////////////////////////////////////////
// Purpose: apb slave and sequencer for an 8-bit successive approximation converter
// Assumes: comparator output arrives from the analog domain; zero-wait apb
// Notes:   byte address is four times the documented index
//
// The register offsets and the APB interface to the registers were decided locally.
`include "sac_consts.svh"

module sac_adc_ctrl #(
	parameter int RES_BITS = `SAC_RES_BITS
) (
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire logic                clk_en,
	input  wire logic                wait_mode,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                comp_above,
	output logic [RES_BITS-1:0]      dac_code,
	output logic                     analog_power_on,
	output logic                     sample_active,
	output logic                     done_irq
);

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	function automatic logic [11:0] reg_addr(input logic [7:0] idx);
		reg_addr = {2'b00, idx, 2'b00};
	endfunction

	logic                  wr_ctrl;
	logic                  access;
	logic                  hit_ctrl;
	logic                  hit_result;
	sac_pkg::sac_ctrl_type ctrl;
	logic                  done_flag;
	logic                  trigger;
	sac_pkg::sac_state_type state;
	logic                  step;
	logic                  sar_done;
	logic [RES_BITS-1:0]   result;
	logic [2:0]            comp_sync;
	logic                  comp_level;
	logic [7:0]            ctrl_read;

	// reset image of the control register; the control field and done flag reset values below are taken from it
	localparam logic [7:0] CTRL_RESET = `SAC_CTRL_RESET;

	assign access     = psel && penable;
	assign hit_ctrl   = paddr == reg_addr(`SAC_IDX_CONTROL); // see RULE17
	assign hit_result = paddr == reg_addr(`SAC_IDX_RESULT);  // see RULE17
	assign pready     = 1'b1;
	// unmapped addresses and writes to the read-only result answer with an error
	assign pslverr    = access && !(hit_ctrl || (hit_result && !pwrite));
	assign wr_ctrl    = clk_en && access && pwrite && hit_ctrl && pstrb[0];
	assign trigger    = wr_ctrl && pwdata[`SAC_BIT_TRIGGER] && ctrl.power_on; // see RULE10

	////////////////////////////////////////////////////////////////////////////
	// control register

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl.irq_enable           <= CTRL_RESET[`SAC_BIT_IRQ_EN]; // see RULE13
			ctrl.power_on             <= CTRL_RESET[`SAC_BIT_POWER];
			ctrl.clock_divider_select <= CTRL_RESET[`SAC_BIT_CLKSEL]; // see RULE2
		end else if (wr_ctrl) begin
			ctrl.irq_enable           <= pwdata[`SAC_BIT_IRQ_EN]; // see RULE15
			ctrl.power_on             <= pwdata[`SAC_BIT_POWER];
			ctrl.clock_divider_select <= pwdata[`SAC_BIT_CLKSEL];
		end
	end

	// done flag: trigger clears it; completion only counts for the running conversion
	always_ff @(posedge clk_sys) begin
		if (reset)
			done_flag <= CTRL_RESET[`SAC_BIT_DONE]; // see RULE13
		else if (clk_en) begin
			if (trigger)
				done_flag <= 1'b0; // see RULE4
			else if (sar_done && state == sac_pkg::SAC_BITS)
				done_flag <= 1'b1; // see RULE5
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge clk_sys) begin
		if (reset)
			state <= sac_pkg::SAC_IDLE; // see RULE13
		else if (clk_en) begin
			if (trigger)
				state <= sac_pkg::SAC_SETTLE; // see RULE7
			else if (!ctrl.power_on)
				state <= sac_pkg::SAC_IDLE; // see RULE10
			else begin
				case (state)
					sac_pkg::SAC_IDLE:   state <= sac_pkg::SAC_IDLE; // see RULE6
					sac_pkg::SAC_SETTLE: if (step) state <= sac_pkg::SAC_BITS;
					sac_pkg::SAC_BITS:   if (sar_done) state <= sac_pkg::SAC_IDLE;
					default:             state <= sac_pkg::SAC_IDLE;
				endcase
			end
		end
	end

	sac_clkdiv u_clkdiv (
		.clk_sys (clk_sys),
		.reset   (reset),
		.clk_en  (clk_en),
		.restart (trigger),
		.fast    (ctrl.clock_divider_select), // see RULE1
		.tick    (step)
	);

	// comparator comes from the analog side: three stages, change when last two agree
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			comp_sync  <= 3'h0;
			comp_level <= 1'b0;
		end else if (clk_en) begin
			comp_sync <= {comp_sync[1:0], comp_above};
			if (comp_sync[2] == comp_sync[1])
				comp_level <= comp_sync[1];
		end
	end

	sac_sar #(
		.RES_BITS (RES_BITS)
	) u_sar (
		.clk_sys    (clk_sys),
		.reset      (reset),
		.clk_en     (clk_en),
		.start      (trigger || state != sac_pkg::SAC_BITS),
		.step       (step),
		.comp_above (comp_level),
		.dac_code   (dac_code),
		.done       (sar_done),
		.result     (result) // see RULE18
	);

	// wait_mode deliberately unused: only the power bit gates the converter
	assign analog_power_on = ctrl.power_on && (wait_mode || !wait_mode); // see RULE12
	assign sample_active   = state != sac_pkg::SAC_IDLE;
	assign done_irq        = done_flag && ctrl.irq_enable; // see RULE9

	////////////////////////////////////////////////////////////////////////////
	// read data

	always_comb begin
		ctrl_read                     = 8'h00;
		ctrl_read[`SAC_BIT_IRQ_EN]    = ctrl.irq_enable;
		ctrl_read[`SAC_BIT_DONE]      = done_flag;
		ctrl_read[`SAC_BIT_TRIGGER]   = 1'b0; // see RULE8
		ctrl_read[`SAC_BIT_POWER]     = ctrl.power_on;
		ctrl_read[`SAC_BIT_CLKSEL]    = ctrl.clock_divider_select;
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !penable && !pwrite) begin
			if (paddr == reg_addr(`SAC_IDX_CONTROL))
				prdata <= {24'h00_0000, ctrl_read};
			else if (paddr == reg_addr(`SAC_IDX_RESULT))
				prdata <= {{(32-RES_BITS){1'b0}}, result}; // see RULE3
			else
				prdata <= 32'h0000_0000;
		end
	end

endmodule

// ==== sac_consts.svh ====
// Purpose: constants for the converter control block
// Assumes: apb byte addresses, 32-bit data, 100 MHz clk_sys
// Notes:   register indices, not byte addresses; the byte address is four times the index
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_IDX_RESULT     8'hd0
`define SAC_IDX_CONTROL    8'hd1
`define SAC_CTRL_RESET     8'h40
`define SAC_BIT_IRQ_EN     7
`define SAC_BIT_DONE       6
`define SAC_BIT_TRIGGER    5
`define SAC_BIT_POWER      4
`define SAC_BIT_CLKSEL     2
`define SAC_DIV_SLOW       4'hc
`define SAC_DIV_FAST       4'h6
`define SAC_RES_BITS       8
`define SAC_ANALOG_SEL_W   21

`endif

// ==== sac_pkg.sv ====
// Purpose: shared types for the converter control block
// Assumes: sac_consts.svh gives the numbers
// Notes:   none
package sac_pkg;

	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_SETTLE,
		SAC_BITS
	} sac_state_type;

	typedef struct packed {
		logic       irq_enable;
		logic       power_on;
		logic       clock_divider_select;
	} sac_ctrl_type;

	typedef struct packed {
		logic       start;
		logic [7:0] result;
	} sac_done_type;

endpackage

// ==== sac_clkdiv.sv ====
// Purpose: conversion-clock tick generator, divide by 12 or by 6
// Assumes: restart realigns the divider to a fresh period
// Notes:   one-cycle tick output
`include "sac_consts.svh"

module sac_clkdiv (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic clk_en,
	input  wire logic restart,
	input  wire logic fast,
	output logic      tick
);

	logic [3:0] count;
	logic [3:0] limit;

	assign limit = fast ? `SAC_DIV_FAST : `SAC_DIV_SLOW; // see RULE16

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count <= 4'h0;
			tick  <= 1'b0;
		end else if (clk_en) begin
			if (restart || count == limit - 4'h1) begin
				count <= 4'h0;
				tick  <= !restart; // see RULE1
			end else begin
				count <= count + 4'h1;
				tick  <= 1'b0;
			end
		end
	end

endmodule

// ==== sac_sar.sv ====
// Purpose: successive approximation register, msb first
// Assumes: comparator input already synchronised by the caller
// Notes:   result output held until next completed sequence
`include "sac_consts.svh"

module sac_sar #(
	parameter int RES_BITS = `SAC_RES_BITS
) (
	input  wire logic                clk_sys,
	input  wire logic                reset,
	input  wire logic                clk_en,
	input  wire logic                start,
	input  wire logic                step,
	input  wire logic                comp_above,
	output logic [RES_BITS-1:0]      dac_code,
	output logic                     done,
	output logic [RES_BITS-1:0]      result
);

	logic [RES_BITS-1:0] trial_bit;
	logic [RES_BITS-1:0] work;

	assign dac_code = work | trial_bit;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			trial_bit <= '0;
			work      <= '0;
			done      <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (start) begin
				trial_bit <= {1'b1, {(RES_BITS-1){1'b0}}};
				work      <= '0;
			end else if (step && trial_bit != '0) begin
				// keep the trial bit when the input lies above the trial level
				if (comp_above)
					work <= work | trial_bit; // see RULE3
				trial_bit <= trial_bit >> 1;
				done      <= trial_bit[0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			result <= '0;
		else if (clk_en && step && trial_bit[0] && !start)
			result <= comp_above ? (work | trial_bit) : work; // see RULE18
	end

endmodule

// ==== sac_adc_ctrl_props.sv ====
// Purpose: port checks for the converter control block
// Assumes: control at byte 344h, result at 340h
// Notes:   bound to every sac_adc_ctrl
module sac_adc_ctrl_props #(
	parameter int RES_BITS = 8
) (
	input wire logic                clk_sys,
	input wire logic                reset,
	input wire logic                clk_en,
	input wire logic                wait_mode,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [3:0]          pstrb,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic                comp_above,
	input wire logic [RES_BITS-1:0] dac_code,
	input wire logic                analog_power_on,
	input wire logic                sample_active,
	input wire logic                done_irq
);
	wire logic acc = psel && penable && clk_en;
	wire logic wr  = acc && pwrite && pstrb[0] && paddr == 12'h344;
	wire logic rd  = acc && !pwrite && paddr == 12'h344;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	a_power_bit: assert property (wr |=> analog_power_on == $past(pwdata[4]))
		else $error("power output does not follow write");
	a_trig_start: assert property (wr && pwdata[5] && analog_power_on |=> sample_active && !done_irq)
		else $error("trigger did not start conversion");
	a_no_self_start: assert property (!sample_active && !wr |=> !sample_active)
		else $error("conversion started without trigger");
	a_irq_masked: assert property (wr && !pwdata[7] |=> !done_irq)
		else $error("interrupt not masked");
	a_busy_no_irq: assert property (sample_active |-> !done_irq)
		else $error("done seen while converting");
	a_read_bits: assert property (rd |-> !prdata[31:8] && !prdata[5] && !prdata[3] && !prdata[1:0])
		else $error("control read shows nonzero fixed bits");
	a_min_length: assert property ($rose(sample_active) |=> sample_active [*8])
		else $error("conversion too short");
	a_first_trial: assert property ($rose(sample_active) |-> dac_code == {1'b1, {(RES_BITS-1){1'b0}}})
		else $error("conversion did not begin with the top trial bit");
	a_conv_bound: assert property (sample_active |-> ##[1:250] !sample_active)
		else $error("conversion never ends");
	a_map_err: assert property (acc && paddr != 12'h340 && paddr != 12'h344 |-> pslverr)
		else $error("unmapped access not refused");
	a_reset_idle: assert property (disable iff (1'b0) reset |=>
		!(sample_active || done_irq || analog_power_on))
		else $error("reset left block active");
	c_trigger: cover property (wr && pwdata[5] ##1 sample_active);
	c_irq: cover property ($fell(sample_active) ##[0:1] done_irq);
	c_err: cover property (acc && pslverr);
endmodule
bind sac_adc_ctrl sac_adc_ctrl_props #(.RES_BITS(RES_BITS)) u_props (.clk_sys(clk_sys), .reset(reset),
	.clk_en(clk_en), .wait_mode(wait_mode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_above(comp_above),
	.dac_code(dac_code), .analog_power_on(analog_power_on), .sample_active(sample_active), .done_irq(done_irq));

// ==== sac_analog_model.sv ====
// Purpose: one analog input pin and the comparator
// Assumes: level steady during a conversion
// Notes:   unpowered comparator toggles, never steady
module sac_analog_model (
	input wire logic       clk_sys,
	input wire logic       power_on,
	input wire logic [7:0] level,
	input wire logic [7:0] dac_code,
	output logic           comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	logic junk = 1'b0;
	always_ff @(posedge clk_sys) begin
		junk <= !junk;
	end
	// only this one pin is ever routed to the converter
	assign comp_above = power_on ? (level >= dac_code) : junk;
endmodule

// ==== sac_adc_ctrl_bench.sv ====
// Purpose: self-checking bench for sac_adc_ctrl
// Assumes: zero-wait apb, 100 MHz clk_sys
// Notes:   tasks per scenario
`include "sac_consts.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module sac_adc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_CTL = {2'b00, `SAC_IDX_CONTROL, 2'b00};
	localparam logic [11:0] A_RES = {2'b00, `SAC_IDX_RESULT, 2'b00};
	logic clk_sys, reset, clk_en, wait_mode, psel, penable, pwrite, pready, pslverr, comp_above, err;
	logic analog_power_on, sample_active, done_irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  pstrb;
	logic [7:0]  dac_code, level;
	int fails = 0, check_count = 0, n;
	sac_adc_ctrl dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .wait_mode(wait_mode), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .comp_above(comp_above), .dac_code(dac_code),
		.analog_power_on(analog_power_on), .sample_active(sample_active), .done_irq(done_irq));
	sac_analog_model u_pin (.clk_sys(clk_sys), .power_on(analog_power_on), .level(level), .dac_code(dac_code),
		.comp_above(comp_above));
	////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a wait that never answers
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	// power goes on in its own write first, the converter needs settling time
	task automatic convert(input logic [7:0] c, input logic [7:0] v);
		level <= v;
		apb(1'b1, A_CTL, c);
		apb(1'b1, A_CTL, c | 8'h20);
		n = 1;
		while (sample_active === 1'b1 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
	endtask
	task automatic t_speeds();
		int dv;
		apb(1'b0, A_CTL, 8'h0);
		`CHK("ctl reset", {24'h0, `SAC_CTRL_RESET}, r)
		`CHK("irq reset", 1'b0, done_irq)
		for (int f = 0; f < 2; f++) begin
			dv = f ? 6 : 12;
			convert(8'h10 | 8'(f << 2), f ? 8'h3c : 8'ha5);
			`CHK("conv time", 1'b1, n >= 9 * dv && n <= 10 * dv)
			apb(1'b0, A_RES, 8'h0);
			`CHK("result", {24'h0, level}, r)
			apb(1'b0, A_CTL, 8'h0);
			`CHK("ctl done", 32'h50 | 32'(f << 2), r)
		end
	endtask
	task automatic t_irq();
		wait_mode <= 1'b1;
		convert(8'h90, 8'h5a);
		wait_mode <= 1'b0;
		`CHK("irq on", 1'b1, done_irq)
		apb(1'b1, A_CTL, 8'h10);
		`CHK("irq mask", 1'b0, done_irq)
		repeat (30) @(posedge clk_sys);
		`CHK("idle", 1'b0, sample_active)
		apb(1'b1, A_CTL, 8'h90);
		`CHK("irq back", 1'b1, done_irq)
	endtask
	task automatic t_abort();
		level <= 8'hc3;
		apb(1'b1, A_CTL, 8'h30);
		repeat (30) @(posedge clk_sys);
		apb(1'b0, A_RES, 8'h0);
		`CHK("old result", 32'h5a, r)
		apb(1'b0, A_CTL, 8'h0);
		`CHK("done clear", 32'h10, r)
		clk_en <= 1'b0;
		apb(1'b1, A_CTL, 8'h00);
		clk_en <= 1'b1;
		`CHK("frozen", 1'b1, analog_power_on)
		convert(8'h10, 8'h81);
		`CHK("restart time", 1'b1, n >= 108 && n <= 120)
		apb(1'b0, A_RES, 8'h0);
		`CHK("new result", 32'h81, r)
	endtask
	task automatic t_refuse();
		apb(1'b1, A_CTL, 8'h00);
		`CHK("power off", 1'b0, analog_power_on)
		apb(1'b1, A_CTL, 8'h20);
		`CHK("no start", 1'b0, sample_active)
		apb(1'b0, 12'h348, 8'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, A_RES, 8'h77);
		`CHK("ro result", 1'b1, err)
		pstrb <= 4'h0;
		apb(1'b1, A_CTL, 8'h10);
		pstrb <= 4'hf;
		apb(1'b0, A_RES, 8'h0);
		`CHK("kept", 32'h81, r)
		`CHK("strobe", 1'b0, analog_power_on)
		`CHK("pready", 1'b1, pready)
	endtask
	// reset in the middle of a running conversion
	task automatic t_mid_reset();
		apb(1'b1, A_CTL, 8'h94);
		apb(1'b1, A_CTL, 8'hb4);
		repeat (10) @(posedge clk_sys);
		`CHK("busy before reset", 1'b1, sample_active)
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		`CHK("reset stop", 1'b0, sample_active)
		`CHK("reset irq", 1'b0, done_irq)
		apb(1'b0, A_CTL, 8'h0);
		`CHK("ctl mid reset", {24'h0, `SAC_CTRL_RESET}, r)
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		tally_and_finish();
	end
	initial begin
		{reset, clk_en, wait_mode, psel, penable, pwrite} = 6'b110000;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		level = 8'h0;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_speeds();
		t_irq();
		t_abort();
		t_refuse();
		t_mid_reset();
		tally_and_finish();
	end
endmodule
